// ---- logic/lsb_top.sv ----
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// - 320-word buffer, send 1 to 320 words
// - Serial timing from system or peripheral clock
// - System clock divided by 13 times 1,2,4,8,16
// - Bit rate limited to ten Mbit/s on system clock
// - Defaults: peripheral clock, MSB first, FIFO
// - Static, write, send; static after reset/stop
// - Config: source, ratio, expansion, DMA, lead-in
// - Settings accepted only in static
// - Settings kept across stop until rewritten
// - Write mode stores each word in order
// - Fill command acts as fixed-polarity line
// - Write mode drives lead-in polarity out
// - Send starts with lead-in run if enabled
// - Words follow with bit and buffer order
// - Busy low throughout sending
// - Line done releases busy, asserts interrupt
// - Repeat command resends held line
// - Stop accepted in write and send
// - Reset: outputs high, data output low
// - DMA request low until count completes
// - Interrupt cleared by access or toggle
module lsb_top
(
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    // AXI4-Lite write address and data
    input  wire logic [11:0]              s_axi_awaddr_i,
    input  wire logic                     s_axi_awvalid_i,
    output logic                          s_axi_awready_o,
    input  wire logic [31:0]              s_axi_wdata_i,
    input  wire logic [3:0]               s_axi_wstrb_i,
    input  wire logic                     s_axi_wvalid_i,
    output logic                          s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0]                    s_axi_bresp_o,
    output logic                          s_axi_bvalid_o,
    input  wire logic                     s_axi_bready_i,
    // AXI4-Lite read
    input  wire logic [11:0]              s_axi_araddr_i,
    input  wire logic                     s_axi_arvalid_i,
    output logic                          s_axi_arready_o,
    output logic [31:0]                   s_axi_rdata_o,
    output logic [1:0]                    s_axi_rresp_o,
    output logic                          s_axi_rvalid_o,
    input  wire logic                     s_axi_rready_i,
    // DMA store port
    input  wire logic [lsb_pkg::WORD_W-1:0] host_data_bus_i,
    input  wire logic                     dma_write_i,
    input  wire logic                     dma_acknowledge_n_i,
    output logic                          dma_request_n_o,
    // Peripheral side
    input  wire logic                     clk_req_i,
    input  wire logic                     toggle_input_i,
    output logic                          ser_data_o,
    output logic                          ser_clk_o,
    output logic                          busy_output_ready_n_o,
    output logic                          line_done_irq_n_o
);
    import lsb_pkg::*;

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw, input logic [3:0] strb);
        merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    endfunction

    // ****************************************
    // State
    // ****************************************
    lsb_state_t        state_q;
    logic [7:0]        cfg_q;
    logic [1:0]        fmt_q;
    logic [15:0]       lead_len_q;
    logic [8:0]        dma_cnt_q;
    logic [8:0]        line_len_q;
    logic              fill_q;
    logic [8:0]        dma_done_q;
    logic [15:0]       lead_left_q;
    logic [8:0]        word_left_q;
    logic [8:0]        rd_ptr_q;
    logic [3:0]        bit_q;
    logic              req_prev_q;
    logic              tog_prev_q;
    logic              ser_data_q;
    logic              ser_clk_q;
    logic              busy_n_q;
    logic              irq_n_q;
    logic              dma_request_n_n_q;

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic              aw_full_q;
    logic              w_full_q;
    logic [11:0]       aw_addr_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              awready_q;
    logic              wready_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              arready_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;

    wire aw_hs   = s_axi_awvalid_i && awready_q;
    wire w_hs    = s_axi_wvalid_i && wready_q;
    wire ar_hs   = s_axi_arvalid_i && arready_q;
    wire wr_fire = aw_full_q && w_full_q && !bvalid_q;
    wire wr_map  = (aw_addr_q[1:0] == 2'b00) && (aw_addr_q <= ADDR_STATUS);
    wire in_stat = (state_q == ST_STATIC);

    wire wr_cfg  = wr_fire && aw_addr_q == ADDR_CONFIG && in_stat;
    wire wr_fmt  = wr_fire && aw_addr_q == ADDR_FORMAT && in_stat;
    wire wr_lead = wr_fire && aw_addr_q == ADDR_LEADIN && in_stat;
    wire wr_dcnt = wr_fire && aw_addr_q == ADDR_DMACNT && in_stat;
    wire wr_cmd  = wr_fire && aw_addr_q == ADDR_CMD && w_strb_q[0];
    wire wr_data = wr_fire && aw_addr_q == ADDR_DATA;
    wire wr_fill = wr_fire && aw_addr_q == ADDR_FILL && state_q == ST_WRITE;
    wire [7:0] cmd = w_data_q[7:0];

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end
        else
        begin
            awready_q <= !aw_full_q && !aw_hs;
            wready_q  <= !w_full_q && !w_hs;
            if (aw_hs)
            begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr_i;
            end
            if (w_hs)
            begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata_i;
                w_strb_q <= s_axi_wstrb_i;
            end
            if (wr_fire)
            begin
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_map ? RESP_OKAY : RESP_SLVERR;
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
            end
            else if (bvalid_q && s_axi_bready_i)
                bvalid_q <= 1'b0;
        end
    end

    wire [31:0] status_word = {7'h00, line_len_q, 10'h000, fill_q, dma_request_n_n_q, irq_n_q, busy_n_q, 2'(state_q)};
    wire        rd_map      = (s_axi_araddr_i[1:0] == 2'b00) && (s_axi_araddr_i <= ADDR_STATUS);
    logic [31:0] rd_mux;

    always_comb
    begin
        case (s_axi_araddr_i)
            ADDR_CONFIG: rd_mux = {24'h000000, cfg_q};
            ADDR_FORMAT: rd_mux = {30'h00000000, fmt_q};
            ADDR_LEADIN: rd_mux = {16'h0000, lead_len_q};
            ADDR_DMACNT: rd_mux = {23'h000000, dma_cnt_q};
            ADDR_STATUS: rd_mux = status_word;
            default:     rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= RESP_OKAY;
        end
        else
        begin
            arready_q <= !rvalid_q && !ar_hs;
            if (ar_hs)
            begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_mux;
                rresp_q  <= rd_map ? RESP_OKAY : RESP_SLVERR;
            end
            else if (rvalid_q && s_axi_rready_i)
                rvalid_q <= 1'b0;
        end
    end

    // ****************************************
    // Settings
    // ****************************************
    // reset values select defaults
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_q      <= CONFIG_RST;
            fmt_q      <= FORMAT_RST;
            lead_len_q <= LEADIN_RST;
            dma_cnt_q  <= DMACNT_RST;
        end
        else
        begin
            if (wr_cfg && w_strb_q[0])
                cfg_q <= w_data_q[7:0];
            if (wr_fmt && w_strb_q[0])
                fmt_q <= w_data_q[1:0];
            if (wr_lead)
                lead_len_q <= merge16(lead_len_q, w_data_q, w_strb_q);
            if (wr_dcnt)
                dma_cnt_q <= 9'(merge16({7'h00, dma_cnt_q}, w_data_q, w_strb_q));
        end
    end

    // ****************************************
    // Bit timing
    // ****************************************
    wire sys_clk  = cfg_q[CFG_SYSCLK];
    wire lead_pol = cfg_q[CFG_LEAD_POL];
    wire sending  = (state_q == ST_SEND);
    wire div_fall;
    wire div_rise;

    lsb_bit_clock u_bit_clock
    (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n),
        .run_i       (sending && sys_clk),
        .ratio_sel_i (cfg_q[CFG_RATIO_LO+2:CFG_RATIO_LO]),
        .fall_o      (div_fall),
        .rise_o      (div_rise)
    );

    wire req_fall = req_prev_q && !clk_req_i;
    wire bit_ev   = sending && (sys_clk ? div_fall : req_fall);

    // ****************************************
    // Line buffer
    // ****************************************
    lsb_mem_if mem_bus ();

    lsb_line_mem u_line_mem
    (
        .clk_i (clk_i),
        .mem   (mem_bus.mem)
    );

    wire dma_cyc  = state_q == ST_WRITE && cfg_q[CFG_DMA] && !dma_acknowledge_n_i && dma_write_i;
    wire room     = line_len_q < LINE_MAX && !fill_q;
    wire store    = (dma_cyc || wr_data && state_q == ST_WRITE && w_strb_q[1:0] == 2'b11) && room;

    assign mem_bus.we    = store;
    assign mem_bus.waddr = line_len_q;
    assign mem_bus.wdata = dma_cyc ? host_data_bus_i : w_data_q[15:0];
    assign mem_bus.raddr = rd_ptr_q;

    wire [15:0] word    = fill_q ? {16{lead_pol}} : mem_bus.rdata;
    wire        cur_bit = fmt_q[FMT_LSB] ? word[bit_q] : word[4'hF - bit_q];
    wire        lifo    = fmt_q[FMT_LIFO];

    // ****************************************
    // Commands
    // ****************************************
    // mode commands; only stop while busy
    wire cmd_stop   = wr_cmd && cmd == CMD_STOP && !in_stat;
    wire cmd_write  = wr_cmd && cmd == CMD_WRITE && in_stat;
    wire cmd_send   = wr_cmd && cmd == CMD_SEND && state_q == ST_WRITE && line_len_q != 9'h000;
    wire cmd_repeat = wr_cmd && cmd == CMD_REPEAT && !sending && line_len_q != 9'h000;
    wire go_send    = cmd_send || cmd_repeat;
    wire last_ev    = bit_ev && lead_left_q == 16'h0000 && word_left_q == 9'h000;
    wire tog_rise   = cfg_q[CFG_EXPAND] && toggle_input_i && !tog_prev_q;
    wire host_touch = aw_hs || ar_hs;

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q     <= ST_STATIC;
            line_len_q  <= 9'h000;
            fill_q      <= 1'b0;
            dma_done_q  <= 9'h000;
            lead_left_q <= 16'h0000;
            word_left_q <= 9'h000;
            rd_ptr_q    <= 9'h000;
            bit_q       <= 4'h0;
            req_prev_q  <= 1'b1;
            tog_prev_q  <= 1'b0;
            ser_data_q  <= 1'b0;
            ser_clk_q   <= 1'b1;
            busy_n_q    <= 1'b1;
            irq_n_q     <= 1'b1;
            dma_request_n_n_q    <= 1'b1;
        end
        else
        begin
            req_prev_q <= clk_req_i;
            tog_prev_q <= toggle_input_i;
            if (host_touch || tog_rise)
                irq_n_q <= 1'b1;
            if (store)
                line_len_q <= line_len_q + 9'h001;
            if (dma_cyc)
            begin
                dma_done_q <= dma_done_q + 9'h001;
                if (dma_done_q + 9'h001 >= dma_cnt_q)
                    dma_request_n_n_q <= 1'b1;
            end
            if (wr_fill)
            begin
                line_len_q <= (w_data_q[15:0] > 16'(LINE_MAX)) ? LINE_MAX : w_data_q[8:0];
                fill_q     <= 1'b1;
            end
            if (sending && sys_clk && div_fall && !last_ev)
                ser_clk_q <= 1'b0;
            else if (!sending || !sys_clk || div_rise)
                ser_clk_q <= 1'b1;
            if (cmd_stop)
            begin
                state_q    <= ST_STATIC;
                busy_n_q   <= 1'b1;
                dma_request_n_n_q   <= 1'b1;
                ser_data_q <= 1'b0;
            end
            else if (cmd_write)
            begin
                state_q    <= ST_WRITE;
                line_len_q <= 9'h000;
                fill_q     <= 1'b0;
                dma_done_q <= 9'h000;
                dma_request_n_n_q   <= !(cfg_q[CFG_DMA] && dma_cnt_q != 9'h000);
                ser_data_q <= lead_pol;
            end
            else if (go_send)
            begin
                state_q     <= ST_SEND;
                dma_request_n_n_q    <= 1'b1;
                busy_n_q    <= 1'b0;
                lead_left_q <= cfg_q[CFG_LEAD_EN] ? lead_len_q : 16'h0000;
                word_left_q <= line_len_q;
                rd_ptr_q    <= lifo ? line_len_q - 9'h001 : 9'h000;
                bit_q       <= 4'h0;
            end
            else if (last_ev)
            begin
                state_q    <= ST_STATIC;
                busy_n_q   <= 1'b1;
                irq_n_q    <= 1'b0;
                ser_data_q <= 1'b0;
            end
            else if (bit_ev)
            begin
                if (lead_left_q != 16'h0000)
                begin
                    ser_data_q  <= lead_pol;
                    lead_left_q <= lead_left_q - 16'h0001;
                end
                else
                begin
                    ser_data_q <= cur_bit;
                    bit_q      <= bit_q + 4'h1;
                    if (bit_q == 4'hF)
                    begin
                        word_left_q <= word_left_q - 9'h001;
                        rd_ptr_q    <= lifo ? rd_ptr_q - 9'h001 : rd_ptr_q + 9'h001;
                    end
                end
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign s_axi_awready_o       = awready_q;
    assign s_axi_wready_o        = wready_q;
    assign s_axi_bvalid_o        = bvalid_q;
    assign s_axi_bresp_o         = bresp_q;
    assign s_axi_arready_o       = arready_q;
    assign s_axi_rvalid_o        = rvalid_q;
    assign s_axi_rdata_o         = rdata_q;
    assign s_axi_rresp_o         = rresp_q;
    assign dma_request_n_o       = dma_request_n_n_q;
    assign ser_data_o            = ser_data_q;
    assign ser_clk_o             = ser_clk_q;
    assign busy_output_ready_n_o = busy_n_q;
    assign line_done_irq_n_o     = irq_n_q;

endmodule

// ---- logic/lsb_pkg.sv ----
package lsb_pkg;

    // ****************************************
    // Clock and serial rate
    // ****************************************
    localparam int unsigned CLK_HZ           = 125_000_000;
    localparam int unsigned MAX_BIT_RATE_BPS = 10_000_000;
    localparam int unsigned CYC_PER_BIT      = (CLK_HZ + MAX_BIT_RATE_BPS - 1) / MAX_BIT_RATE_BPS;
    localparam int unsigned MAX_RATIO_SEL    = 4;

    // ****************************************
    // Line buffer geometry
    // ****************************************
    localparam int unsigned LINE_WORDS = 320;
    localparam int unsigned WORD_W     = 16;
    localparam int unsigned PTR_W      = 9;
    localparam logic [8:0]  LINE_MAX   = 9'h140;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [11:0] ADDR_CONFIG = 12'h000;
    localparam logic [11:0] ADDR_FORMAT = 12'h004;
    localparam logic [11:0] ADDR_LEADIN = 12'h008;
    localparam logic [11:0] ADDR_DMACNT = 12'h00C;
    localparam logic [11:0] ADDR_CMD    = 12'h010;
    localparam logic [11:0] ADDR_DATA   = 12'h014;
    localparam logic [11:0] ADDR_FILL   = 12'h018;
    localparam logic [11:0] ADDR_STATUS = 12'h01C;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int unsigned CFG_SYSCLK   = 0;
    localparam int unsigned CFG_RATIO_LO = 1;
    localparam int unsigned CFG_EXPAND   = 4;
    localparam int unsigned CFG_DMA      = 5;
    localparam int unsigned CFG_LEAD_EN  = 6;
    localparam int unsigned CFG_LEAD_POL = 7;
    localparam int unsigned FMT_LSB      = 0;
    localparam int unsigned FMT_LIFO     = 1;
    localparam logic [7:0]  CONFIG_RST   = 8'h00;
    localparam logic [1:0]  FORMAT_RST   = 2'h0;
    localparam logic [15:0] LEADIN_RST   = 16'h0000;
    localparam logic [8:0]  DMACNT_RST   = 9'h000;

    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [7:0] CMD_WRITE  = 8'h01;
    localparam logic [7:0] CMD_SEND   = 8'h02;
    localparam logic [7:0] CMD_STOP   = 8'h03;
    localparam logic [7:0] CMD_REPEAT = 8'h04;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_STATIC = 2'b00,
        ST_WRITE  = 2'b01,
        ST_SEND   = 2'b10
    } lsb_state_t;

endpackage

// ---- logic/lsb_mem_if.sv ----
`timescale 1ns/10ps
interface lsb_mem_if;
    import lsb_pkg::*;
    logic              we;
    logic [PTR_W-1:0]  waddr;
    logic [WORD_W-1:0] wdata;
    logic [PTR_W-1:0]  raddr;
    logic [WORD_W-1:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ---- logic/lsb_line_mem.sv ----
`timescale 1ns/10ps
module lsb_line_mem
(
    // Clock
    input  wire logic clk_i,
    // Buffer port
    lsb_mem_if.mem    mem
);
    import lsb_pkg::*;

    logic [WORD_W-1:0] words [LINE_WORDS];

    always_ff @(posedge clk_i)
    begin
        if (mem.we)
        begin
            words[mem.waddr] <= mem.wdata;
        end
    end

    assign mem.rdata = words[mem.raddr];

endmodule

// ---- logic/lsb_bit_clock.sv ----
`timescale 1ns/10ps
module lsb_bit_clock
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Control
    input  wire logic       run_i,
    input  wire logic [2:0] ratio_sel_i,
    // Bit timing pulses
    output logic            fall_o,
    output logic            rise_o
);
    import lsb_pkg::*;

    logic [8:0] cnt_q;
    logic [8:0] period;
    logic [8:0] half;
    logic [2:0] sel;

    assign sel    = (ratio_sel_i > 3'(MAX_RATIO_SEL)) ? 3'(MAX_RATIO_SEL) : ratio_sel_i;
    assign period = 9'(CYC_PER_BIT) << sel;
    assign half   = period >> 1;
    assign fall_o = run_i && (cnt_q == 9'h000);
    assign rise_o = run_i && (cnt_q == half);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_q <= 9'h000;
        else if (!run_i || cnt_q == period - 9'h001)
            cnt_q <= 9'h000;
        else
            cnt_q <= cnt_q + 9'h001;
    end

endmodule

// ---- bench/lsb_periph_model.sv ----
`timescale 1ns/10ps
module lsb_periph_model
(
    // Bench side
    input  wire logic clk_i,
    input  wire logic run_i,
    // Peripheral request clock
    output logic      clk_req_o
);
    logic [3:0] cnt_q = 4'h0;
    logic       req_q = 1'b1;
    assign clk_req_o = req_q;
    always @(posedge clk_i)
    begin
        cnt_q <= run_i ? cnt_q + 4'h1 : 4'h0;
        req_q <= !(run_i && cnt_q[3]);
    end
endmodule

// ---- bench/lsb_top_assertions.sv ----
`timescale 1ns/10ps
module lsb_top_assertions
    import lsb_pkg::*;
(
    // Clock, reset and watched ports
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0]  s_axi_rresp_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic        dma_request_n_o,
    input wire logic        ser_data_o,
    input wire logic        busy_output_ready_n_o,
    input wire logic        line_done_irq_n_o
);
    // ****************
    // Checks
    // ****************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_ar_take;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence
    sequence s_line_end;
        $rose(busy_output_ready_n_o) ##0 !ser_data_o;
    endsequence
    chk_line_end: assert property ($fell(line_done_irq_n_o) |-> s_line_end)
        else $error("bad line end");
    chk_busy_irq: assert property (!busy_output_ready_n_o |-> line_done_irq_n_o)
        else $error("irq low while busy");
    chk_irq_clear: assert property (s_ar_take ##0 !line_done_irq_n_o |=> line_done_irq_n_o)
        else $error("irq not cleared");
    chk_dma_request_n_start: assert property ($fell(dma_request_n_o) |-> $rose(s_axi_bvalid_o))
        else $error("dma_request_n fell alone");
    chk_b_done: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
        else $error("bvalid stuck");
    chk_r_done: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
        else $error("rvalid stuck");
    chk_r_lat: assert property (s_ar_take |=> s_axi_rvalid_o)
        else $error("read answer late");
    chk_err_data: assert property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR |-> s_axi_rdata_o == 32'h0)
        else $error("error read with data");
endmodule

bind lsb_top lsb_top_assertions lsb_top_assertions_inst (.clk_i, .rst_n_i, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .dma_request_n_o, .ser_data_o, .busy_output_ready_n_o, .line_done_irq_n_o);

// ---- bench/line_scan_serial_buffer_test.sv ----
`timescale 1ns/10ps
module line_scan_serial_buffer_test;
    import lsb_pkg::*;
    logic        clk_i, rst_n_i, awv, wv, bready, arv, rready, dma_wr, dma_acknowledge_n_n, run, clk_req, toggle_input;
    logic        awready, wready, bvalid, arready, rvalid, dma_request_n_n, sdata, sclk, busy_n, irq_n;
    logic [1:0]  bresp, rresp;
    logic [11:0] awaddr, araddr;
    logic [15:0] hd;
    logic [31:0] wdata, rdata, rd;
    logic [63:0] bits;
    time         t_prev, t_last;
    int          error_cnt = 0, n_tests = 0, cyc = 0;
    localparam logic [63:0] LINE_B = {29'h0, 3'b111, 16'h8001, 16'h2C48};

    lsb_top lsb_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .host_data_bus_i(hd),
        .dma_write_i(dma_wr), .dma_acknowledge_n_i(dma_acknowledge_n_n), .dma_request_n_o(dma_request_n_n), .clk_req_i(clk_req),
        .toggle_input_i(toggle_input), .ser_data_o(sdata), .ser_clk_o(sclk), .busy_output_ready_n_o(busy_n),
        .line_done_irq_n_o(irq_n));
    lsb_periph_model lsb_periph_model_inst (.clk_i(clk_i), .run_i(run), .clk_req_o(clk_req));

    // ****************
    // Clock and tasks
    // ****************
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            test_done();
        end
    end
    task chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        {aw_ok, w_ok} = 2'b00;
        @(posedge clk_i);
        {awaddr, wdata, awv, wv, bready} <= {a, d, 3'b111};
        while (!(aw_ok && w_ok))
        begin
            @(posedge clk_i);
            aw_ok = aw_ok || awready === 1'b1;
            w_ok = w_ok || wready === 1'b1;
            awv <= !aw_ok;
            wv <= !w_ok;
        end
        do @(posedge clk_i); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, RESP_OKAY);
    endtask
    task rdr(input logic [11:0] a, input logic [1:0] er);
        @(posedge clk_i);
        {araddr, arv, rready} <= {a, 2'b11};
        do @(posedge clk_i); while (arready !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk_i); while (rvalid !== 1'b1);
        rready <= 1'b0;
        rd = rdata;
        chk(rresp, er);
    endtask
    task get_bits(input int n, input logic sys);
        bits = '0;
        repeat (n)
        begin
            if (sys) @(posedge sclk);
            else @(posedge clk_req);
            bits = {bits[62:0], sdata};
            t_prev = t_last;
            t_last = $time;
        end
    endtask
    task wait_idle();
        do @(posedge clk_i); while (busy_n !== 1'b1);
        run <= 1'b0;
    endtask
    task test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ****************
    // Scenarios
    // ****************
    task t_reset();
        repeat (5) @(posedge clk_i);
        chk({busy_n, irq_n, dma_request_n_n, sclk, sdata}, 5'b11110);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        $display("reset test done");
    endtask
    task t_default();
        wr(ADDR_CMD, CMD_WRITE);
        wr(ADDR_DATA, 32'hA5C3);
        wr(ADDR_DATA, 32'h0F01);
        wr(ADDR_CMD, CMD_SEND);
        run <= 1'b1;
        get_bits(32, 1'b0);
        chk(bits, 64'hA5C30F01);
        chk(busy_n, 1'b0);
        wait_idle();
        chk(irq_n, 1'b0);
        rdr(ADDR_STATUS, RESP_OKAY);
        chk(rd[1:0], ST_STATIC);
        chk(irq_n, 1'b1);
        $display("default line test done");
    endtask
    task t_sysclk();
        wr(ADDR_CONFIG, 32'hD1);
        wr(ADDR_FORMAT, 32'h3);
        wr(ADDR_LEADIN, 32'h3);
        wr(ADDR_CMD, CMD_WRITE);
        chk(sdata, 1'b1);
        wr(ADDR_DATA, 32'h1234);
        wr(ADDR_DATA, 32'h8001);
        wr(ADDR_CMD, CMD_SEND);
        get_bits(35, 1'b1);
        chk(bits, LINE_B);
        chk(t_last - t_prev, 64'd104);
        wait_idle();
        chk(irq_n, 1'b0);
        toggle_input <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(irq_n, 1'b1);
        $display("system clock test done");
    endtask
    task t_repeat();
        wr(ADDR_CMD, CMD_REPEAT);
        get_bits(35, 1'b1);
        chk(bits, LINE_B);
        wait_idle();
        wr(ADDR_CMD, CMD_REPEAT);
        wr(ADDR_CONFIG, 32'h0);
        wr(ADDR_CMD, CMD_WRITE);
        rdr(ADDR_STATUS, RESP_OKAY);
        chk(rd[1:0], ST_SEND);
        wr(ADDR_CMD, CMD_STOP);
        rdr(ADDR_STATUS, RESP_OKAY);
        chk(rd[2:0], 3'b100);
        wr(ADDR_CMD, CMD_REPEAT);
        get_bits(35, 1'b1);
        chk(bits, LINE_B);
        wait_idle();
        $display("repeat and stop test done");
    endtask
    task t_dma();
        wr(ADDR_CONFIG, 32'h20);
        wr(ADDR_DMACNT, 32'h2);
        wr(ADDR_CMD, CMD_WRITE);
        chk(dma_request_n_n, 1'b0);
        {dma_wr, dma_acknowledge_n_n, hd} <= {2'b10, 16'h1111};
        repeat (2) @(posedge clk_i);
        {dma_wr, dma_acknowledge_n_n} <= 2'b01;
        repeat (2) @(posedge clk_i);
        chk(dma_request_n_n, 1'b1);
        wr(ADDR_CMD, CMD_STOP);
        rdr(12'h020, RESP_SLVERR);
        chk(rd, 32'h0);
        $display("dma test done");
    endtask

    initial
    begin
        {rst_n_i, awv, wv, bready, arv, rready, dma_wr, run, toggle_input} = '0;
        {awaddr, araddr, wdata, hd, dma_acknowledge_n_n} = {72'h0, 1'b1};
        t_reset();
        t_default();
        t_sysclk();
        t_repeat();
        t_dma();
        test_done();
    end
endmodule
